/* logic/dasc_sync_ctrl.sv */
// three-channel loop synchronizer control core with register slave
`timescale 1ns/1ps
`default_nettype none
`include "dasc_cfg.svh"
// Function
// RULE1: each loop has converter, filter, 40-bit divider
// RULE2: digital reference is a pin or cascade
// RULE3: analog reference is oscillator pin or cascade
// RULE4: fixed 40-bit or programmable 24-bit denominator
// RULE5: never cascade one oscillator into both pair inputs
// RULE6: post-divider of one bypasses the divider
// RULE7: frequency step moves the numerator up or down
// RULE8: loop bandwidth kept low by software
// RULE9: analog loops free-run until reference valid
// RULE10: each loop picks reference by own priority
// RULE11: phase compared, word filtered, numerator adjusted
// RULE12: one loop locking leaves others untouched
// RULE13: cascaded and no reference means free-run
// RULE14: main loop acquires, cascaded loops follow it
// RULE15: all enabled locked means outputs synchronized; synced is also held low outside cascade mode
// RULE16: cascaded loops stay locked while main free-runs
// RULE17: software powers down unused loops
// RULE18: software keeps divider fraction away from boundaries
module dasc_sync_ctrl
    import dasc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [3:0] ref_in,
    input wire logic xo_in,
    output wire logic [119:0] an_num,
    output wire logic [71:0] an_den,
    output wire logic [2:0] an_den_prog,
    output wire logic [2:0] dl_locked,
    output wire logic [2:0] al_locked,
    output wire logic [2:0] free_run,
    output logic synced,
    output logic res_dist_clk
);
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [4:0] pin_s3;
    logic [4:0] pin_ok;
    logic [15:0] win_cnt [5];
    logic [`DASC_CTRL_W-1:0] ctrl [3];
    logic [31:0] step [3];
    logic [23:0] num24 [3];
    logic [23:0] den24 [3];
    logic casc_mode;
    logic [3:0] pdiv;
    logic [3:0] pd_cnt;
    logic [2:0] inc_p;
    logic [2:0] dec_p;
    wire logic [2:0] fb_vec;
    wire logic [2:0] al_vec;
    wire logic [2:0] ok_vec;
    wire logic [7:0] stat_w [3];
    wire logic [39:0] num_w [3];

    function automatic logic [31:0] bmerge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] sel
    );
        for (int k = 0; k < 4; k++) begin
            bmerge[k*8 +: 8] = sel[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
        end
    endfunction

    // lowest index among eligible valid references wins
    function automatic logic [2:0] pri_pick(input logic [3:0] ok);
        pri_pick = `DASC_SEL_NONE;
        for (int k = 3; k >= 0; k--) begin
            if (ok[k]) begin
                pri_pick = 3'(k);
            end
        end
    endfunction

    // bus decode
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr = req && wb_we_i;
    wire logic in_map = !wb_adr_i[`DASC_ADR_TOP];
    wire logic [1:0] grp = wb_adr_i[6:5];
    wire logic [2:0] ridx = wb_adr_i[4:2];
    wire logic is_glb = (grp == `DASC_GRP_GLB);
    wire logic [2:0] ch_wr = (wr && in_map && !is_glb) ?
        3'(3'b001 << grp) : 3'b000;
    wire logic g_wr = wr && in_map && is_glb && ridx == `DASC_G_CTRL;
    wire logic [2:0] dco_wr = (ridx == `DASC_R_DCO && wb_sel_i[0]) ?
        ch_wr : 3'b000;
    wire logic [4:0] pin_edge = pin_s2 & ~pin_s3;
    wire logic [31:0] glb_ctrl = {24'h00_0000, pdiv, 3'b000, casc_mode};
    wire logic [31:0] glb_stat = {26'h000_0000, pin_ok, synced};
    wire logic [31:0] glb_word =
        (ridx == `DASC_G_CTRL) ? glb_ctrl :
        (ridx == `DASC_G_STAT) ? glb_stat : 32'h0000_0000;
    wire logic [31:0] ch_word =
        (ridx == `DASC_R_CTRL) ? 32'(ctrl[grp]) :
        (ridx == `DASC_R_STEP) ? step[grp] :
        (ridx == `DASC_R_NUM24) ? 32'(num24[grp]) :
        (ridx == `DASC_R_DEN24) ? 32'(den24[grp]) :
        (ridx == `DASC_R_STAT) ? 32'(stat_w[grp]) :
        (ridx == `DASC_R_NUMRD) ? num_w[grp][31:0] : 32'h0000_0000;
    wire logic [31:0] rd_word = !in_map ? 32'h0000_0000 :
        (is_glb ? glb_word : ch_word);

    // wishbone answer one cycle after the request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= (req && !wb_we_i) ? rd_word : 32'h0000_0000;
        end
    end

    // three-stage capture of reference and oscillator pins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_s1 <= 5'h00;
            pin_s2 <= 5'h00;
            pin_s3 <= 5'h00;
        end else begin
            pin_s1 <= {xo_in, ref_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // a pin stays valid while edges keep arriving within the window
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 5; i++) begin
                win_cnt[i] <= 16'h0000;
            end
            pin_ok <= 5'h00;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (pin_edge[i]) begin
                    win_cnt[i] <= 16'h0000;
                    pin_ok[i] <= 1'b1;
                end else if (win_cnt[i] == `DASC_REF_WIN_CYC) begin
                    pin_ok[i] <= 1'b0;
                end else begin
                    win_cnt[i] <= win_cnt[i] + 16'h0001;
                end
            end
        end
    end

    // per-channel configuration registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                ctrl[i] <= `DASC_CTRL_RST;
                step[i] <= 32'h0000_0000;
                num24[i] <= 24'h00_0000;
                den24[i] <= 24'h00_0001;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (ch_wr[i] && ridx == `DASC_R_CTRL) begin
                    ctrl[i] <= `DASC_CTRL_W'(
                        bmerge(32'(ctrl[i]), wb_dat_i, wb_sel_i));
                end
                if (ch_wr[i] && ridx == `DASC_R_STEP) begin
                    step[i] <= bmerge(step[i], wb_dat_i, wb_sel_i);
                end
                if (ch_wr[i] && ridx == `DASC_R_NUM24) begin
                    num24[i] <= 24'(
                        bmerge(32'(num24[i]), wb_dat_i, wb_sel_i));
                end
                if (ch_wr[i] && ridx == `DASC_R_DEN24) begin
                    den24[i] <= 24'(
                        bmerge(32'(den24[i]), wb_dat_i, wb_sel_i));
                end
            end
        end
    end

    // global control and one-cycle frequency step commands
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            casc_mode <= 1'b0;
            pdiv <= `DASC_PD_RST;
            inc_p <= 3'b000;
            dec_p <= 3'b000;
        end else begin
            if (g_wr && wb_sel_i[0]) begin
                casc_mode <= wb_dat_i[`DASC_G_CASC];
                pdiv <= wb_dat_i[`DASC_G_PD_HI:`DASC_G_PD_LO];
            end
            inc_p <= dco_wr & {3{wb_dat_i[`DASC_DCO_INC]}};
            dec_p <= dco_wr & {3{wb_dat_i[`DASC_DCO_DEC]}};
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_ch
        dasc_loop_if lp ();
        logic [15:0] al_cnt;
        logic al_lk;
        logic dl_lk;
        logic fr_q;
        logic [39:0] num_q;
        logic [23:0] den_q;
        logic den_prog_q;

        wire logic [`DASC_CTRL_W-1:0] c = ctrl[g];
        // RULE14 in cascade the non-main loops follow the main domain
        wire logic casc = casc_mode && (2'(g) != `DASC_MAIN_CH);
        wire logic [2:0] sel_f = c[`DASC_C_SEL_HI:`DASC_C_SEL_LO];
        wire logic [1:0] src_f = casc ? `DASC_MAIN_CH :
            c[`DASC_C_CSRC_HI:`DASC_C_CSRC_LO];
        // RULE10 own priority within this loop's eligible mask
        wire logic [2:0] pick = (sel_f == `DASC_SEL_AUTO) ?
            pri_pick(pin_ok[3:0] & c[`DASC_C_MASK_HI:`DASC_C_MASK_LO]) :
            sel_f;
        // RULE2 reference mux: pin or another loop's cascade output
        wire logic use_casc = casc || (sel_f == `DASC_SEL_CASC);
        wire logic pin_sel = !use_casc && pick[2] == 1'b0;
        wire logic dref_edge = use_casc ? fb_vec[src_f] :
            (pin_sel && pin_edge[pick[1:0]]);
        // RULE16 cascaded loops judge only their cascade input
        wire logic dref_ok = use_casc ? al_vec[src_f] :
            (pin_sel && pin_ok[pick[1:0]]);
        // RULE3 analog reference: oscillator pin or cascade output
        wire logic aref_ok = c[`DASC_C_AL_CASC] ? al_vec[src_f] :
            pin_ok[`DASC_XO_IDX];

        // RULE9 digital loop runs only on a settled analog loop
        assign lp.en = c[`DASC_C_DL_EN] && al_lk;
        assign lp.valid = dref_ok;
        assign lp.ref_edge = dref_edge;
        assign lp.dco_en = c[`DASC_C_DCO_EN];
        assign lp.inc = inc_p[g];
        assign lp.dec = dec_p[g];
        assign lp.step = step[g];

        // RULE12 each loop owns its state
        dasc_loop u_loop (
            .clock(clock),
            .rst(rst),
            .lp(lp.loop)
        );

        assign fb_vec[g] = lp.fb_edge;
        assign al_vec[g] = al_lk;
        assign ok_vec[g] = (!c[`DASC_C_DL_EN] || dl_lk) &&
            (!c[`DASC_C_AL_EN] || al_lk);
        assign stat_w[g] = {1'b0, pick, dref_ok, fr_q, al_lk, dl_lk};
        assign num_w[g] = num_q;
        assign an_num[g*40 +: 40] = num_q;
        assign an_den[g*24 +: 24] = den_q;
        assign an_den_prog[g] = den_prog_q;
        assign dl_locked[g] = dl_lk;
        assign al_locked[g] = al_lk;
        assign free_run[g] = fr_q;

        // RULE13 analog loop settles on its reference after a delay
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                al_cnt <= 16'h0000;
                al_lk <= 1'b0;
            end else if (!c[`DASC_C_AL_EN] || !aref_ok) begin
                al_cnt <= 16'h0000;
                al_lk <= 1'b0;
            end else if (al_cnt == `DASC_AL_LOCK_CYC) begin
                al_lk <= 1'b1;
            end else begin
                al_cnt <= al_cnt + 16'h0001;
            end
        end

        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                dl_lk <= 1'b0;
                fr_q <= 1'b0;
                num_q <= `DASC_NUM_NOM;
                den_q <= 24'h00_0000;
                den_prog_q <= 1'b0;
            end else begin
                dl_lk <= lp.locked;
                // RULE9 free-run until the digital loop holds lock
                fr_q <= al_lk && !lp.locked;
                // RULE4 denominator choice for the analog divider
                den_prog_q <= c[`DASC_C_DEN_PROG];
                den_q <= c[`DASC_C_DEN_PROG] ? den24[g] : 24'h00_0000;
                num_q <= c[`DASC_C_DEN_PROG] ? 40'(num24[g]) : lp.num;
            end
        end
    end

    // RULE15 synchronized once cascade mode is on and every enabled loop is locked
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            synced <= 1'b0;
        end else begin
            synced <= casc_mode && (&ok_vec);
        end
    end

    // RULE6 post-divider for the resonator channel output
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pd_cnt <= 4'h0;
            res_dist_clk <= 1'b0;
        end else if (fb_vec[`DASC_MAIN_CH]) begin
            if (pdiv <= `DASC_PD_BYPASS) begin
                pd_cnt <= 4'h0;
                res_dist_clk <= !res_dist_clk;
            end else if (pd_cnt >= pdiv - 4'h1) begin
                pd_cnt <= 4'h0;
                res_dist_clk <= !res_dist_clk;
            end else begin
                pd_cnt <= pd_cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* logic/dasc_cfg.svh */
// offsets, field positions, reset values and timing counts
`ifndef DASC_CFG_SVH
`define DASC_CFG_SVH
`define DASC_CLK_MHZ 50
`define DASC_ADR_TOP 7
`define DASC_GRP_GLB 2'h3
`define DASC_R_CTRL 3'h0
`define DASC_R_STEP 3'h1
`define DASC_R_DCO 3'h2
`define DASC_R_NUM24 3'h3
`define DASC_R_DEN24 3'h4
`define DASC_R_STAT 3'h5
`define DASC_R_NUMRD 3'h6
`define DASC_G_CTRL 3'h0
`define DASC_G_STAT 3'h1
`define DASC_C_DL_EN 0
`define DASC_C_AL_EN 1
`define DASC_C_DCO_EN 2
`define DASC_C_DEN_PROG 3
`define DASC_C_SEL_LO 4
`define DASC_C_SEL_HI 6
`define DASC_C_CSRC_LO 7
`define DASC_C_CSRC_HI 8
`define DASC_C_AL_CASC 9
`define DASC_C_MASK_LO 10
`define DASC_C_MASK_HI 13
`define DASC_CTRL_W 14
`define DASC_CTRL_RST 14'h3c00
`define DASC_G_CASC 0
`define DASC_G_PD_LO 4
`define DASC_G_PD_HI 7
`define DASC_PD_RST 4'h1
`define DASC_PD_BYPASS 4'h1
`define DASC_DCO_INC 0
`define DASC_DCO_DEC 1
`define DASC_SEL_AUTO 3'h4
`define DASC_SEL_CASC 3'h5
`define DASC_SEL_NONE 3'h7
`define DASC_XO_IDX 4
`define DASC_MAIN_CH 2'h2
`define DASC_NUM_NOM 40'h01_0000_0000
`define DASC_LOCK_TOL 16'sh0002
`define DASC_LOCK_N 8'h10
`define DASC_DLF_SHIFT 3
`define DASC_DLF_GAIN 8
`define DASC_REF_WIN_NS 40000
`define DASC_REF_WIN_CYC 16'((`DASC_REF_WIN_NS * `DASC_CLK_MHZ) / 1000)
`define DASC_AL_LOCK_NS 20000
`define DASC_AL_LOCK_CYC 16'((`DASC_AL_LOCK_NS * `DASC_CLK_MHZ + 999) / 1000)
`endif

/* logic/dasc_pkg.sv */
// types shared by the synchronizer control modules
package dasc_pkg;
    typedef enum logic [1:0] {
        DASC_ST_IDLE = 2'b00,
        DASC_ST_ACQ = 2'b01,
        DASC_ST_TRACK = 2'b10,
        DASC_ST_LOCK = 2'b11
    } dasc_lst_t;
endpackage

/* logic/dasc_loop_if.sv */
// signals between the control core and one digital loop
`timescale 1ns/1ps
`default_nettype none
interface dasc_loop_if;
    logic en;
    logic valid;
    logic dco_en;
    logic inc;
    logic dec;
    logic ref_edge;
    logic [31:0] step;
    logic [39:0] num;
    logic fb_edge;
    logic locked;
    modport ctl (
        output en, valid, dco_en, inc, dec, ref_edge, step,
        input num, fb_edge, locked
    );
    modport loop (
        input en, valid, dco_en, inc, dec, ref_edge, step,
        output num, fb_edge, locked
    );
endinterface
`default_nettype wire

/* logic/dasc_loop.sv */
// one digital loop: phase converter, loop filter, 40-bit divider
`timescale 1ns/1ps
`default_nettype none
`include "dasc_cfg.svh"
module dasc_loop
    import dasc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    dasc_loop_if.loop lp
);
    logic [39:0] acc;
    logic [39:0] num;
    logic fb_edge;
    logic signed [15:0] ph;
    logic signed [15:0] filt;
    logic [7:0] good;
    dasc_lst_t st;
    dasc_lst_t next_st;

    // RULE1 fractional feedback divider carry
    wire logic [40:0] acc_sum = {1'b0, acc} + {1'b0, num};
    // RULE11 phase count of reference against feedback
    wire logic signed [15:0] ph_nxt = (lp.ref_edge == fb_edge) ? ph :
        (lp.ref_edge ? ph + 16'sh0001 : ph - 16'sh0001);
    // RULE11 smoothing of the correction word
    wire logic signed [15:0] f_nxt =
        filt + ((ph_nxt - filt) >>> `DASC_DLF_SHIFT);
    wire logic [39:0] corr = 40'(f_nxt) <<< `DASC_DLF_GAIN;
    wire logic upd = lp.ref_edge &&
        (st == DASC_ST_TRACK || st == DASC_ST_LOCK);
    wire logic in_tol = (ph_nxt <= `DASC_LOCK_TOL) &&
        (ph_nxt >= -`DASC_LOCK_TOL);
    wire logic run = lp.en && lp.valid;
    // RULE7 frequency step up or down
    wire logic [39:0] dco_adj = !lp.dco_en ? 40'h00_0000_0000 :
        lp.inc ? 40'(lp.step) :
        lp.dec ? 40'h00_0000_0000 - 40'(lp.step) : 40'h00_0000_0000;

    assign lp.num = num;
    assign lp.fb_edge = fb_edge;
    assign lp.locked = (st == DASC_ST_LOCK);

    always_comb begin
        next_st = st;
        case (st)
            DASC_ST_IDLE: begin
                if (run) begin
                    next_st = DASC_ST_ACQ;
                end
            end
            DASC_ST_ACQ: begin
                if (lp.ref_edge) begin
                    next_st = DASC_ST_TRACK;
                end
            end
            DASC_ST_TRACK: begin
                if (lp.ref_edge && in_tol && good == `DASC_LOCK_N) begin
                    next_st = DASC_ST_LOCK;
                end
            end
            DASC_ST_LOCK: begin
                if (lp.ref_edge && !in_tol) begin
                    next_st = DASC_ST_TRACK;
                end
            end
            default: next_st = DASC_ST_IDLE;
        endcase
        if (!run) begin
            next_st = DASC_ST_IDLE;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st <= DASC_ST_IDLE;
            acc <= 40'h00_0000_0000;
            fb_edge <= 1'b0;
        end else begin
            st <= next_st;
            acc <= acc_sum[39:0];
            fb_edge <= acc_sum[40];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ph <= 16'sh0000;
            filt <= 16'sh0000;
            good <= 8'h00;
        end else if (st == DASC_ST_IDLE || st == DASC_ST_ACQ) begin
            // RULE11 first word cancels the phase unfiltered
            ph <= (lp.ref_edge || st == DASC_ST_IDLE) ? 16'sh0000 : ph_nxt;
            filt <= 16'sh0000;
            good <= 8'h00;
        end else begin
            ph <= ph_nxt;
            if (lp.ref_edge) begin
                filt <= f_nxt;
                good <= !in_tol ? 8'h00 :
                    (good == `DASC_LOCK_N ? good : good + 8'h01);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            num <= `DASC_NUM_NOM;
        end else if (!lp.en) begin
            num <= `DASC_NUM_NOM;
        end else begin
            // RULE11 filtered word steers the numerator
            num <= num + dco_adj + (upd ? corr : 40'h00_0000_0000);
        end
    end
endmodule
`default_nettype wire

/* tb/dasc_sync_ctrl_chk.sv */
// assertions on the synchronizer control ports
`timescale 1ns/1ps
`default_nettype none
`include "dasc_cfg.svh"
module dasc_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [119:0] an_num,
    input wire logic [71:0] an_den,
    input wire logic [2:0] an_den_prog,
    input wire logic [2:0] dl_locked,
    input wire logic [2:0] al_locked,
    input wire logic [2:0] free_run
);
    localparam int AL_WAIT = 1000;
    logic [10:0] up_cnt;
    wire logic [71:0] den_mask;
    assign den_mask = {{24{~an_den_prog[2]}}, {24{~an_den_prog[1]}},
                       {24{~an_den_prog[0]}}};
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            up_cnt <= 11'h000;
        end else if (up_cnt < 11'(AL_WAIT)) begin
            up_cnt <= up_cnt + 11'h001;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_needs_req: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    a_num_after_rst: assert property (
        $fell(rst) |-> an_num == {3{`DASC_NUM_NOM}})
        else $error("numerator not nominal after reset");
    a_den_fixed_zero: assert property (
        (an_den & den_mask) == 72'h0)
        else $error("fixed denominator channel shows programmed value");
    a_free_run_def: assert property (
        free_run == ($past(al_locked) & ~dl_locked))
        else $error("free run flag disagrees with lock flags");
    a_al_lock_early: assert property (
        al_locked != 3'h0 |-> up_cnt >= 11'(AL_WAIT))
        else $error("analog lock earlier than settle time");
endmodule
bind dasc_sync_ctrl dasc_chk i_dasc_chk (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .an_num(an_num),
    .an_den(an_den), .an_den_prog(an_den_prog), .dl_locked(dl_locked),
    .al_locked(al_locked), .free_run(free_run)
);
`default_nettype wire

/* tb/dasc_ref_src.sv */
// reference pins and oscillator pin driven from the far side
`timescale 1ns/1ps
`default_nettype none
module dasc_ref_src #(
    parameter int XO_HALF = 30,
    parameter int REF_HALF = 220
) (
    input wire logic [3:0] ref_run,
    input wire logic xo_run,
    output logic [3:0] ref_in,
    output logic xo_in
);
    // oscillator period three times the clock period
    initial begin
        xo_in = 1'b0;
        forever begin
            #(XO_HALF);
            xo_in = xo_run ? ~xo_in : 1'b0;
        end
    end
    // references stand low while stopped
    // reference edges far apart for slow loops
    for (genvar i = 0; i < 4; i++) begin : g_ref
        initial begin
            ref_in[i] = 1'b0;
            forever begin
                #(REF_HALF + 20 * i);
                ref_in[i] = ref_run[i] ? ~ref_in[i] : 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// register bus tests of the synchronizer control core
`timescale 1ns/1ps
`default_nettype none
`include "dasc_cfg.svh"
module testbench;
    logic clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, xo_run;
    logic synced, res_dist_clk, rdc_q;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, ref_run;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    wire logic [3:0] ref_in;
    wire logic xo_in;
    logic [119:0] an_num;
    logic [71:0] an_den;
    logic [2:0] an_den_prog, dl_locked, al_locked, free_run;
    int err_total, cmp_count, tgl;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    dasc_sync_ctrl i_dasc_sync_ctrl (.clock(clock), .rst(rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_in(ref_in),
        .xo_in(xo_in), .an_num(an_num), .an_den(an_den),
        .an_den_prog(an_den_prog), .dl_locked(dl_locked),
        .al_locked(al_locked), .free_run(free_run), .synced(synced),
        .res_dist_clk(res_dist_clk));
    dasc_ref_src i_dasc_ref_src (.ref_run(ref_run), .xo_run(xo_run),
        .ref_in(ref_in), .xo_in(xo_in));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wb_cycle(input logic we, input logic [7:0] adr,
                            input logic [31:0] d, input logic [3:0] sel);
        int n;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 40) begin
            err_total++;
            $display("mismatch wb_ack expected 1 seen 0");
        end
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        wb_cycle(1'b1, adr, d, 4'hf);
    endtask
    task automatic chk(input string name, input logic [39:0] exp,
                       input logic [39:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rdchk(input string name, input logic [7:0] adr,
                         input logic [31:0] exp, input logic [31:0] msk);
        wb_cycle(1'b0, adr, 32'h0000_0000, 4'hf);
        chk(name, {8'h00, exp & msk}, {8'h00, rd & msk});
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        $display("mismatch watchdog expected done seen hang");
        stop_test();
    end
    initial begin
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        ref_run = 4'h0;
        xo_run = 1'b1;
        err_total = 0;
        cmp_count = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        for (int g = 0; g < 3; g++) begin
            rdchk("ctrl", 8'(g * 32), 32'h0000_3c00, ALL);
            rdchk("den24", 8'(g * 32 + 16), 32'h0000_0001, ALL);
            chk("an_num", `DASC_NUM_NOM, an_num[g * 40 +: 40]);
        end
        rdchk("gctrl", 8'h60, 32'h0000_0010, 32'h0000_00f1);
        rdchk("unmapped", 8'h80, 32'h0000_0000, ALL);
        $display("test reset done");
        wr(8'h24, 32'h1234_5678);
        wb_cycle(1'b1, 8'h24, 32'haaaa_bbbb, 4'h5);
        rdchk("step", 8'h24, 32'h12aa_56bb, ALL);
        wr(8'h00, 32'h0000_3c07);
        wr(8'h04, 32'h0000_0010);
        repeat (1100) @(posedge clock);
        wr(8'h08, 32'h0000_0001);
        repeat (4) @(posedge clock);
        chk("num_inc", 40'h01_0000_0010, an_num[39:0]);
        rdchk("numrd", 8'h18, 32'h0000_0010, ALL);
        rdchk("dco_rd", 8'h08, 32'h0000_0000, ALL);
        wr(8'h08, 32'h0000_0002);
        wr(8'h08, 32'h0000_0002);
        wr(8'h28, 32'h0000_0001);
        repeat (4) @(posedge clock);
        chk("num_dec", 40'h00_ffff_fff0, an_num[39:0]);
        chk("num_off", `DASC_NUM_NOM, an_num[79:40]);
        chk("num_ch2", `DASC_NUM_NOM, an_num[119:80]);
        $display("test dco done");
        wr(8'h50, 32'h0012_3456);
        wr(8'h40, 32'h0000_3c08);
        repeat (3) @(posedge clock);
        chk("den_prog", 40'h4, {37'h0, an_den_prog});
        chk("den_val", 40'h12_3456, {16'h0, an_den[71:48]});
        $display("test denominator done");
        wr(8'h20, 32'h0000_3c02);
        tgl = 0;
        repeat (1024) begin
            rdc_q = res_dist_clk;
            @(posedge clock);
            if (res_dist_clk !== rdc_q) begin
                tgl++;
            end
        end
        repeat (76) @(posedge clock);
        chk("res_toggles", 40'h4, 40'(tgl));
        chk("al_locked", 40'h3, {37'h0, al_locked});
        chk("free_run", 40'h3, {37'h0, free_run});
        rdchk("stat1", 8'h34, 32'h0000_0006, 32'h0000_0007);
        rdchk("gstat", 8'h64, 32'h0000_0020, 32'h0000_003f);
        $display("test free run done");
        wr(8'h60, 32'h0000_0011);
        // analog refs from oscillator, main digital ref on pin 0, other digital refs cascaded
        wr(8'h00, 32'h0000_3c02);
        wr(8'h40, 32'h0000_3c03);
        repeat (1100) @(posedge clock);
        chk("casc_al", 40'h7, {37'h0, al_locked});
        chk("casc_fr", 40'h7, {37'h0, free_run});
        chk("synced", 40'h0, {39'h0, synced});
        ref_run <= 4'h1;
        wr(8'h40, 32'h0000_3c03);
        repeat (200) @(posedge clock);
        rdchk("stat2", 8'h54, 32'h0000_0008, 32'h0000_0008);
        rdchk("gstat_ref", 8'h64, 32'h0000_0022, 32'h0000_003f);
        chk("casc_keep", 40'h3, {38'h0, al_locked[1:0]});
        ref_run <= 4'h0;
        repeat (2100) @(posedge clock);
        rdchk("gstat_lost", 8'h64, 32'h0000_0020, 32'h0000_003f);
        $display("test cascade done");
        stop_test();
    end
endmodule
`default_nettype wire
